//--- logic/abs_pkg.sv
// package for the buffer-mode conversion sequencer: register map, fields, timing
// assumes a 32-bit avalon-mm slave with waitrequest, one 50 MHz clock
// ==========================================================================
// Notes on behaviour
// - 1-buffer: result goes to channel's own register
// - 1-buffer serial: done pulse every conversion
// - keep reconverting same channel while enabled
// - clearing enable stops all further conversions
// - results overwrite unread registers; reader fetches promptly
// - parallel: four overlapping staggered conversions
// - stagger equals quarter of configured conversion time
// - 1-buffer parallel: done pulse every quarter time
// - 4-buffer serial: four results, four registers
// - channel 0-3 to regs 0-3, 4-7 to 4-7
// - 4-buffer serial: done after fourth conversion only
// - 4-buffer parallel: done after four results stored
// - channels 6 and 7 only in large variant
// - setting enable starts conversion
// - buffer mode bit selects 1 or 4 buffers
// - operation bit selects serial or parallel
// - channel write aborts, discards, restarts new channel
package abs_pkg;
  // ========================================================================
  // register word offsets (byte address = 4 * index)
  localparam logic [3:0] ADDR_POWER_ENABLE = 4'h0;
  localparam logic [3:0] ADDR_TIMING       = 4'h1;
  localparam logic [3:0] ADDR_CHANNEL      = 4'h2;
  localparam logic [3:0] ADDR_MODE         = 4'h3;
  localparam logic [3:0] ADDR_STATUS       = 4'h4;
  localparam logic [3:0] ADDR_RESULT0      = 4'h8;
  localparam int         ADDR_W            = 4;
  // ========================================================================
  // field positions
  localparam int BIT_ENABLE   = 0;
  localparam int BIT_POWER    = 7;
  localparam int BIT_BUF_MODE = 0;
  localparam int BIT_OP_MODE  = 1;
  localparam int BIT_BUSY     = 0;
  localparam int BIT_DONE_STK = 1;
  localparam int TIME_W       = 16;
  localparam int CH_W         = 3;
  localparam int RES_W        = 16;
  localparam int LANES        = 4;
  localparam logic [1:0] LANE_LAST = 2'h3;
  // ========================================================================
  // reset values; the conversion time is counted in clock cycles
  localparam logic [TIME_W-1:0] TIMING_RESET = 16'h0100;
  localparam logic [TIME_W-1:0] TIME_MIN     = 16'h0004;
  localparam logic [31:0]       UNMAPPED_RD  = 32'h0000_0000;
  typedef enum logic [1:0] {ABS_IDLE, ABS_RUN} abs_state_e;
endpackage

//--- logic/abs_result_if.sv
// write channel between the sequencer core and the result memory
// assumes one clock shared by both sides
`timescale 1ns/1ns
interface abs_result_if #(parameter int DEPTH = 8, parameter int W = 16);
  logic                     wrEn;
  logic [$clog2(DEPTH)-1:0] wrIdx;
  logic [W-1:0]             wrData;
  logic [$clog2(DEPTH)-1:0] rdIdx;
  logic [W-1:0]             rdData;
  modport core (output wrEn, output wrIdx, output wrData, output rdIdx, input rdData);
  modport mem  (input wrEn, input wrIdx, input wrData, input rdIdx, output rdData);
endinterface

//--- logic/abs_result_mem.sv
// result register bank; read data come out of a register one cycle after rdIdx
// assumes rdIdx held stable by the bus master while it waits
`timescale 1ns/1ns
module abs_result_mem #(
  parameter int DEPTH = 8,
  parameter int W     = 16
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  abs_result_if.mem  port
);
  logic [W-1:0] store_ff [DEPTH];
  logic [W-1:0] rdData_ff;

  // new result overwrites whether or not it was read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        store_ff[i] <= '0;
      end
      rdData_ff <= '0;
    end else begin
      if (port.wrEn) begin
        store_ff[port.wrIdx] <= port.wrData;
      end
      rdData_ff <= store_ff[port.rdIdx];
    end
  end
  assign port.rdData = rdData_ff;
endmodule

//--- logic/abs_sequencer.sv
// buffer-mode conversion sequencer: avalon-mm registers, four staggered
// conversion lanes, result routing and the conversion-done pulse
// assumes the analog sample is presented on sampleIn, synchronous to clk
`timescale 1ns/1ns
module abs_sequencer #(
  parameter int NUM_CH = 8   // 6 for the smaller variant
) (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic [abs_pkg::ADDR_W-1:0]   address,
  input  wire logic                         read,
  input  wire logic                         write,
  input  wire logic [31:0]                  writedata,
  input  wire logic [3:0]                   byteenable,
  output logic      [31:0]                  readdata,
  output logic                              waitrequest,
  input  wire logic [abs_pkg::RES_W-1:0]    sampleIn,
  output logic                              convDoneIrq,
  output logic                              powerOn
);
  localparam int IDX_W = $clog2(8);

  // ========================================================================
  // control registers
  logic                           enable_ff;
  logic                           power_ff;
  logic [abs_pkg::TIME_W-1:0]     timing_ff;
  logic [abs_pkg::CH_W-1:0]       channel_ff;
  logic                           bufMode_ff;
  logic                           opMode_ff;
  logic                           doneSticky_ff;
  logic                           convDoneIrq_ff;
  logic [31:0]                    readdata_ff;
  logic                           rdPend_ff;
  abs_pkg::abs_state_e            state_ff;

  // ========================================================================
  // bus decode
  function automatic logic hit(input logic [abs_pkg::ADDR_W-1:0] a,
                               input logic [abs_pkg::ADDR_W-1:0] b);
    hit = (a == b);
  endfunction

  wire wrAcc    = write && !read;
  wire wrEnable = wrAcc && hit(address, abs_pkg::ADDR_POWER_ENABLE) && byteenable[0];
  wire wrTiming = wrAcc && hit(address, abs_pkg::ADDR_TIMING) && byteenable[0];
  wire wrChan   = wrAcc && hit(address, abs_pkg::ADDR_CHANNEL) && byteenable[0];
  wire wrMode   = wrAcc && hit(address, abs_pkg::ADDR_MODE) && byteenable[0];
  wire isResult = address >= abs_pkg::ADDR_RESULT0;
  wire [IDX_W-1:0] resIdx = address[IDX_W-1:0];
  wire resValid = isResult && (32'(resIdx) < NUM_CH);
  // result reads take one wait cycle for the memory register
  wire rdRes    = read && resValid;
  wire rdStat   = read && hit(address, abs_pkg::ADDR_STATUS);

  // ========================================================================
  // sequencing
  wire running  = (state_ff == abs_pkg::ABS_RUN);
  wire abortReq = wrChan && running;
  wire [abs_pkg::TIME_W-1:0] convTime =
    (timing_ff < abs_pkg::TIME_MIN) ? abs_pkg::TIME_MIN : timing_ff;
  // stagger is a quarter of the conversion time
  wire [abs_pkg::TIME_W-1:0] quarter = convTime >> 2;
  wire [1:0] laneCnt = opMode_ff ? 2'(abs_pkg::LANES - 1) : 2'h0;

  logic [abs_pkg::TIME_W-1:0] elapsed_ff [abs_pkg::LANES];
  logic [abs_pkg::LANES-1:0]  active_ff;
  logic [abs_pkg::TIME_W-1:0] launch_ff;
  logic [1:0]                 launched_ff;
  logic [1:0]                 slot_ff;
  logic [2:0]                 groupCnt_ff;

  // only one lane can finish in a cycle since starts are staggered
  logic [abs_pkg::LANES-1:0]  laneDone;
  genvar g;
  generate
    for (g = 0; g < abs_pkg::LANES; g++) begin : g_lane
      assign laneDone[g] = active_ff[g] && (elapsed_ff[g] == convTime - 1'b1);
    end
  endgenerate
  wire anyDone = |laneDone && running && enable_ff && !abortReq;

  // launching: serial relaunches lane 0 on completion, parallel staggers lanes
  wire serialRelaunch = !opMode_ff && laneDone[0];
  wire parLaunch      = opMode_ff && (launched_ff != 2'(abs_pkg::LANE_LAST)) &&
                        (launch_ff == quarter - 1'b1);

  // result routing: own register in 1-buffer group of four otherwise
  wire [IDX_W-1:0] groupBase = {channel_ff[2], 2'b00};
  wire [IDX_W-1:0] wrIdx     = bufMode_ff ? (groupBase | IDX_W'(slot_ff))
                                          : IDX_W'(channel_ff);
  // done after one result in 1-buffer after four in 4-buffer
  wire groupFull = bufMode_ff ? (slot_ff == abs_pkg::LANE_LAST) : 1'b1;

  abs_result_if #(.DEPTH(8), .W(abs_pkg::RES_W)) res ();
  assign res.wrEn   = anyDone;
  assign res.wrIdx  = wrIdx;
  assign res.wrData = sampleIn;
  assign res.rdIdx  = resIdx;

  abs_result_mem #(.DEPTH(8), .W(abs_pkg::RES_W)) u_mem (
    .clk   (clk),
    .rst_n (rst_n),
    .port  (res.mem)
  );

  wire startReq = wrEnable && writedata[abs_pkg::BIT_ENABLE];
  wire chanOk   = 32'(writedata[abs_pkg::CH_W-1:0]) < NUM_CH;

  // ========================================================================
  // state and control, reset to idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= abs_pkg::ABS_IDLE;
    end else if (wrEnable && !writedata[abs_pkg::BIT_ENABLE]) begin
      state_ff <= abs_pkg::ABS_IDLE;
    end else if (startReq || (enable_ff && running)) begin
      state_ff <= abs_pkg::ABS_RUN;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_ff  <= 1'b0;
      power_ff   <= 1'b0;
      timing_ff  <= abs_pkg::TIMING_RESET;
      channel_ff <= '0;
      bufMode_ff <= 1'b0;
      opMode_ff  <= 1'b0;
    end else begin
      if (wrEnable) begin
        enable_ff <= writedata[abs_pkg::BIT_ENABLE];
        power_ff  <= writedata[abs_pkg::BIT_POWER];
      end
      if (wrTiming) begin
        timing_ff <= writedata[abs_pkg::TIME_W-1:0];
      end
      if (wrChan && chanOk) begin
        channel_ff <= writedata[abs_pkg::CH_W-1:0];
      end
      if (wrMode) begin
        bufMode_ff <= writedata[abs_pkg::BIT_BUF_MODE];
        opMode_ff  <= writedata[abs_pkg::BIT_OP_MODE];
      end
    end
  end

  // lane timers; a fresh start or channel write restarts from lane 0
  wire restart = (startReq && !running) || abortReq || !running;
  generate
    for (g = 0; g < abs_pkg::LANES; g++) begin : g_timer
      wire launchThis = (g == 0) ? serialRelaunch
                                 : (parLaunch && (launched_ff == 2'(g - 1)));
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          active_ff[g]  <= 1'b0;
          elapsed_ff[g] <= '0;
        end else if (restart) begin
          // a channel write restarts lane 0 on the new channel
          active_ff[g]  <= (g == 0) && (startReq || abortReq);
          elapsed_ff[g] <= '0;
        end else if (launchThis || laneDone[g]) begin
          // parallel lanes rerun immediately so spacing stays one quarter
          active_ff[g]  <= 1'b1;
          elapsed_ff[g] <= '0;
        end else if (active_ff[g]) begin
          elapsed_ff[g] <= elapsed_ff[g] + 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      launch_ff   <= '0;
      launched_ff <= '0;
    end else if (restart) begin
      launch_ff   <= '0;
      launched_ff <= '0;
    end else if (parLaunch) begin
      launch_ff   <= '0;
      launched_ff <= launched_ff + 1'b1;
    end else if (launched_ff != laneCnt) begin
      launch_ff   <= launch_ff + 1'b1;
    end
  end

  // group slot advances ascending and wraps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_ff     <= '0;
      groupCnt_ff <= '0;
    end else if (restart) begin
      slot_ff     <= '0;
      groupCnt_ff <= '0;
    end else if (anyDone) begin
      slot_ff     <= bufMode_ff ? slot_ff + 1'b1 : 2'h0;
      groupCnt_ff <= groupCnt_ff + 1'b1;
    end
  end

  // one-cycle done pulse sticky status sets over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      convDoneIrq_ff <= 1'b0;
      doneSticky_ff  <= 1'b0;
    end else begin
      convDoneIrq_ff <= anyDone && groupFull;
      if (anyDone && groupFull) begin
        doneSticky_ff <= 1'b1;
      end else if (rdStat && !rdPend_ff) begin
        doneSticky_ff <= 1'b0;
      end
    end
  end

  // ========================================================================
  // bus answer: writes in the request cycle, every read after one wait cycle so
  // the registered read data already stand at the taking edge
  wire [31:0] statusWord = {30'h0, doneSticky_ff, running};
  logic [31:0] rdMux;
  always_comb begin
    rdMux = abs_pkg::UNMAPPED_RD;
    unique case (1'b1)
      hit(address, abs_pkg::ADDR_POWER_ENABLE): rdMux = {24'h0, power_ff, 6'h0, enable_ff};
      hit(address, abs_pkg::ADDR_TIMING):       rdMux = {16'h0, timing_ff};
      hit(address, abs_pkg::ADDR_CHANNEL):      rdMux = {29'h0, channel_ff};
      hit(address, abs_pkg::ADDR_MODE):         rdMux = {30'h0, opMode_ff, bufMode_ff};
      rdStat:                                   rdMux = statusWord;
      default:                                  rdMux = abs_pkg::UNMAPPED_RD;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdPend_ff   <= 1'b0;
      readdata_ff <= '0;
    end else begin
      rdPend_ff <= read && !rdPend_ff;
      if (read && !rdPend_ff) begin
        readdata_ff <= rdMux;
      end
    end
  end

  assign waitrequest = read && !rdPend_ff;
  assign readdata    = (rdRes && rdPend_ff) ? {16'h0, res.rdData} : readdata_ff;
  assign convDoneIrq = convDoneIrq_ff;
  assign powerOn     = power_ff;

  // ========================================================================
  // checks
  a_irq_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    convDoneIrq |=> !convDoneIrq) else $error("done pulse longer than one cycle");
  a_stop_no_irq: assert property (@(posedge clk) disable iff (!rst_n)
    !enable_ff ##1 !enable_ff |-> !convDoneIrq) else $error("done while disabled");
  a_single_irq_each: assert property (@(posedge clk) disable iff (!rst_n)
    (anyDone && !bufMode_ff) |=> convDoneIrq) else $error("1-buffer result without done");
  a_four_buf_mid: assert property (@(posedge clk) disable iff (!rst_n)
    (anyDone && bufMode_ff && slot_ff != 2'h3) |=> !convDoneIrq)
    else $error("done before group filled");
  a_one_buf_idx: assert property (@(posedge clk) disable iff (!rst_n)
    (res.wrEn && !bufMode_ff) |-> res.wrIdx == IDX_W'(channel_ff))
    else $error("1-buffer wrote wrong register");
  a_group_range: assert property (@(posedge clk) disable iff (!rst_n)
    (res.wrEn && bufMode_ff) |-> res.wrIdx[2] == channel_ff[2])
    else $error("4-buffer wrote outside group");
  a_slot_ascend: assert property (@(posedge clk) disable iff (!rst_n)
    (anyDone && bufMode_ff) |=> slot_ff == $past(slot_ff) + 2'h1)
    else $error("group slot not ascending");
  a_abort_no_store: assert property (@(posedge clk) disable iff (!rst_n)
    abortReq |-> !res.wrEn ##1 !active_ff[1]) else $error("aborted result stored");
  a_idle_after_stop: assert property (@(posedge clk) disable iff (!rst_n)
    (wrEnable && !writedata[0]) |=> !running) else $error("still running after stop");
endmodule

//--- verif/abs_sample_src.sv
// track-and-hold model of the selected analog input channel
// assumes one clock shared with the sequencer; the bench sets the level
`timescale 1ns/1ns
// ==========================================================================
// sample register
module abs_sample_src (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] level,
  output logic      [15:0] sampleOut
);
  // one cycle of lag, like a real sample-and-hold in front of the filter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sampleOut <= 16'h0;
    end else begin
      sampleOut <= level;
    end
  end
endmodule

//--- verif/tb_adc_buffer_mode_sequencer.sv
// self-checking bench for the buffer-mode conversion sequencer
// assumes abs_pkg compiled first; smaller variant with six channels
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, (a), (e)); end end
module tb_adc_buffer_mode_sequencer;
  localparam int T = 16;
  localparam int Q = T >> 2;
  logic                       clk = 1'b0;
  logic                       rst_n = 1'b0;
  logic [abs_pkg::ADDR_W-1:0] address = '0;
  logic                       read = 1'b0;
  logic                       write = 1'b0;
  logic [31:0]                writedata = 32'h0;
  logic [3:0]                 byteenable = 4'hf;
  logic [31:0]                readdata;
  logic                       waitrequest;
  logic [15:0]                level = 16'h0;
  logic [15:0]                sampleIn;
  logic                       convDoneIrq;
  logic                       powerOn;
  logic                       takeFlag = 1'b0;
  logic [31:0]                takeData = 32'h0;
  logic [31:0]                expQ[$];
  logic [31:0]                expVal;
  logic                       prevIrq = 1'b0;
  int                         irqCount = 0;
  int                         serIv = 0;
  int                         failures = 0;
  int                         checked = 0;

  always #10 clk = ~clk;

  abs_sequencer #(.NUM_CH(6)) abs_sequencer_i (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .sampleIn(sampleIn), .convDoneIrq(convDoneIrq),
    .powerOn(powerOn));
  abs_sample_src abs_sample_src_i (
    .clk(clk), .rst_n(rst_n), .level(level), .sampleOut(sampleIn));

  // ========================================================================
  // bus master tasks: request held until the edge that sees waitrequest low
  task automatic bwrite(input logic [3:0] a, input logic [31:0] d);
    address   <= a;
    writedata <= d;
    write     <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic bread(input logic [3:0] a, input logic [31:0] e);
    expQ.push_back(e);
    address <= a;
    read    <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    takeFlag <= 1'b1;
    takeData <= readdata;
    read     <= 1'b0;
    @(posedge clk);
    takeFlag <= 1'b0;
  endtask

  task automatic waitIrq(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (convDoneIrq !== 1'b1 && n < 2000);
  endtask

  task automatic close_out;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ========================================================================
  // monitor: read results against the oldest note, pulse width every cycle
  always @(posedge clk) begin
    if (takeFlag) begin
      expVal = expQ.pop_front();
      `CHK(takeData, expVal)
    end
    if (rst_n) begin
      `CHK(convDoneIrq & prevIrq, 1'b0)
    end
    prevIrq = convDoneIrq;
    if (convDoneIrq === 1'b1) irqCount++;
  end

  // ========================================================================
  // one buffer/operation combination: start, spacing, storage, stop
  task automatic runMode(input logic [1:0] m);
    int          n;
    int          c0;
    logic [2:0]  ch;
    logic [15:0] s;
    ch = 3'($urandom % 6);
    s  = 16'($urandom);
    bwrite(abs_pkg::ADDR_MODE, {30'h0, m});
    bwrite(abs_pkg::ADDR_CHANNEL, {29'h0, ch});
    bwrite(abs_pkg::ADDR_POWER_ENABLE, 32'h81);
    waitIrq(n);
    `CHK(n <= 5 * T, 1'b1)
    waitIrq(n);
    case (m)
      2'd0: begin
        serIv = n;
        `CHK(n >= T && n <= T + 2, 1'b1)
      end
      2'd1: `CHK(n, 4 * serIv)
      2'd2: `CHK(n, Q)
      default: `CHK(n, 4 * Q)
    endcase
    level <= s;
    waitIrq(n);
    waitIrq(n);
    if (!m[0]) begin
      bread(abs_pkg::ADDR_RESULT0 + 4'(ch), {16'h0, s});
    end else begin
      for (int k = 0; k < 4; k++) begin
        bread(abs_pkg::ADDR_RESULT0 + 4'(ch & 3'h4) + 4'(k), {16'h0, s});
      end
    end
    bwrite(abs_pkg::ADDR_POWER_ENABLE, 32'h80);
    repeat (2) @(posedge clk);
    c0 = irqCount;
    repeat (3 * T) @(posedge clk);
    `CHK(irqCount, c0)
    `CHK(powerOn, 1'b1)
  endtask

  // ========================================================================
  // main sequence
  initial begin
    int          n;
    logic [2:0]  a;
    logic [2:0]  b;
    logic [15:0] s0;
    logic [15:0] s;
    void'($urandom(89153));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK(powerOn, 1'b0)
    `CHK(convDoneIrq, 1'b0)
    bread(abs_pkg::ADDR_TIMING, {16'h0, abs_pkg::TIMING_RESET});
    bread(abs_pkg::ADDR_STATUS, 32'h0);
    bread(4'h5, abs_pkg::UNMAPPED_RD);
    bwrite(abs_pkg::ADDR_TIMING, 32'(T));
    for (int m = 0; m < 4; m++) runMode(2'(m));
    // channel change mid-conversion: old result kept, new channel restarts
    a  = 3'($urandom % 6);
    b  = 3'((a + 1) % 6);
    s0 = 16'($urandom);
    s  = ~s0;
    level <= s0;
    bwrite(abs_pkg::ADDR_MODE, 32'h0);
    bwrite(abs_pkg::ADDR_CHANNEL, {29'h0, a});
    bwrite(abs_pkg::ADDR_POWER_ENABLE, 32'h81);
    waitIrq(n);
    repeat (T / 2) @(posedge clk);
    level <= s;
    bwrite(abs_pkg::ADDR_CHANNEL, {29'h0, b});
    waitIrq(n);
    `CHK(n >= T - 1, 1'b1)
    bread(abs_pkg::ADDR_RESULT0 + 4'(b), {16'h0, s});
    bread(abs_pkg::ADDR_RESULT0 + 4'(a), {16'h0, s0});
    bwrite(abs_pkg::ADDR_CHANNEL, 32'h7);
    bread(abs_pkg::ADDR_CHANNEL, {29'h0, b});
    bwrite(abs_pkg::ADDR_POWER_ENABLE, 32'h0);
    repeat (4) @(posedge clk);
    close_out;
  end

  // hang guard, far beyond the several hundred cycles the tests need
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    close_out;
  end
endmodule
